// [src/mlt_apply.sv]
// Applies the table result to one set point and limits both outputs
`timescale 1ns/100ps
module mlt_apply import mlt_pkg::*; #(
  parameter logic signed [31:0] V_MAX = 32'h0001_86A0,
  parameter logic signed [31:0] I_MAX = 32'h0001_86A0
) (
  input wire logic core_clk, // Clock
  input wire logic resetn, // Async reset, active low
  input wire logic [1:0] ctl_sel, // Which set point is modulated
  input wire logic ctl_type, // Multiply or add
  input wire logic signed [31:0] vref, // Voltage set point, mV
  input wire logic signed [31:0] iref, // Current set point, mA
  input wire logic signed [31:0] mod_val, // Table result, thousandths
  input wire logic mod_ok, // Table result is usable
  output logic signed [31:0] vout, // Final voltage set point
  output logic signed [31:0] iout // Final current set point
);
  logic signed [31:0] vplain;
  logic signed [31:0] iplain;
  logic signed [31:0] nxt_vout;
  logic signed [31:0] nxt_iout;

  // Combine and clamp; the supply cannot go below zero or past its rating
  function automatic logic signed [31:0] mlt_mix(input logic signed [31:0] r,
      input logic signed [31:0] m, input logic t, input logic signed [31:0] lim);
    logic signed [63:0] v;
    if (t == TYPE_MUL) v = (64'(r) * 64'(m)) / MILLI;
    else v = 64'(r) + 64'(m);
    if (v < 0) v = '0;
    else if (v > 64'(lim)) v = 64'(lim);
    return v[31:0];
  endfunction

  assign vplain = mlt_mix(vref, 32'h0000_0000, TYPE_ADD, V_MAX);
  assign iplain = mlt_mix(iref, 32'h0000_0000, TYPE_ADD, I_MAX);

  // Only the selected set point sees the table
  always_comb begin
    nxt_vout = vplain;
    nxt_iout = iplain;
    if (mod_ok && ctl_sel == CTL_VOLT) begin
      nxt_vout = mlt_mix(vref, mod_val, ctl_type, V_MAX);
    end else if (mod_ok && ctl_sel == CTL_CURR) begin
      nxt_iout = mlt_mix(iref, mod_val, ctl_type, I_MAX);
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      vout <= '0;
      iout <= '0;
    end else begin
      vout <= nxt_vout;
      iout <= nxt_iout;
    end
  end

  a_floor_zero: assert property (@(posedge core_clk) disable iff (!resetn)
    vout >= 0 && iout >= 0 && vout <= V_MAX && iout <= I_MAX)
    else $error("set point outside supply limits");
  a_one_setpt: assert property (@(posedge core_clk) disable iff (!resetn)
    ctl_sel != CTL_VOLT |=> vout == $past(vplain))
    else $error("voltage modulated while not selected");
  a_mode_off: assert property (@(posedge core_clk) disable iff (!resetn)
    ctl_sel == CTL_OFF |=> vout == $past(vplain) && iout == $past(iplain))
    else $error("modulation active while disabled");
endmodule // mlt_apply

// [src/mlt_core.sv]
// Modulation lookup-table engine: tables, commands, store and interpolation
`timescale 1ns/100ps
module mlt_core import mlt_pkg::*; #(
  parameter logic signed [31:0] V_MAX = 32'h0001_86A0,
  parameter logic signed [31:0] I_MAX = 32'h0001_86A0,
  parameter logic signed [31:0] V_INIT = 32'h0000_0000,
  parameter logic signed [31:0] I_INIT = 32'h0000_0000
) (
  input wire logic core_clk, // Clock, 25 MHz
  input wire logic resetn, // Async reset, active low
  input wire logic cmd_valid, // Host command present
  output logic cmd_ready, // Command can be taken
  input wire mlt_op_t cmd_op, // Write, read, save or load
  input wire logic [ROW_W-1:0] cmd_row, // Row number 1..50
  input wire logic signed [DW-1:0] cmd_vpt, // Input point, mV
  input wire logic signed [DW-1:0] cmd_mod, // Value, thousandths
  input wire logic [1:0] cmd_loc, // Table selector
  input wire logic cmd_has_sp, // Load carries set points
  input wire logic signed [DW-1:0] cmd_vset, // New voltage set point
  input wire logic signed [DW-1:0] cmd_iset, // New current set point
  output logic rsp_valid, // Answer pulse
  output logic rsp_err, // Command refused
  output logic [ROW_W-1:0] rsp_row, // Answer row
  output logic signed [DW-1:0] rsp_vpt, // Answer point
  output logic signed [DW-1:0] rsp_mod, // Answer value
  output logic [1:0] rsp_loc, // Answer selector
  input wire logic analog_modulation_valid, // New input sample
  input wire logic [15:0] analog_modulation_input, // Input sample, mV
  input wire logic [1:0] ctl_sel, // Modulated set point choice
  input wire logic ctl_type, // Multiply or add
  output logic nvm_req, // Store access request
  output logic nvm_we, // Store access is a write
  output logic [ROW_W-1:0] nvm_addr, // Store row
  output logic [63:0] nvm_wdata, // Row to store: point, value
  input wire logic [63:0] nvm_rdata, // Row read back: point, value
  input wire logic nvm_ack, // Store access finished
  output logic boot_done, // Tables restored
  output logic signed [DW-1:0] mod_val, // Current table result
  output logic mod_ok, // Table result usable
  output logic signed [DW-1:0] vout_sp, // Final voltage set point
  output logic signed [DW-1:0] iout_sp // Final current set point
);
  typedef enum logic [1:0] {C_BOOT, C_IDLE, C_SAVE} mlt_cst_t;
  typedef enum logic [1:0] {I_IDLE, I_SCAN, I_DIV} mlt_ist_t;

  mlt_cst_t cst_ff;
  mlt_ist_t ist_ff;
  logic signed [DW-1:0] act_vpt_ff [ROWS];
  logic signed [DW-1:0] act_mod_ff [ROWS];
  logic signed [DW-1:0] cch_vpt_ff [ROWS];
  logic signed [DW-1:0] cch_mod_ff [ROWS];
  logic [ROW_W-1:0] nvm_row_ff;
  logic signed [DW-1:0] vset_ff;
  logic signed [DW-1:0] iset_ff;
  logic [ROW_W-1:0] ix_ff;
  logic signed [DW-1:0] vin_ff;
  logic signed [DW-1:0] m0_ff;
  logic neg_ff;
  logic start_ff;
  logic [DIV_W-1:0] num_ff;
  logic [DIV_W-1:0] den_ff;
  logic take;
  logic last_ack;
  logic [ROW_W-1:0] ri;
  logic [ROW_W-1:0] ixp;
  logic row_ok;
  logic vpt_ok;
  logic val_ok;
  logic loc_ok;
  logic wr_ok;
  logic signed [DW-1:0] vp;
  logic signed [DW-1:0] mp;
  logic signed [DW-1:0] mp0;
  logic signed [DW-1:0] dm;
  logic signed [DW-1:0] dm_abs;
  logic signed [DW-1:0] dvin;
  logic signed [DW-1:0] dden;

  mlt_div_if #(.W(DIV_W)) dv ();

  // Commands wait while the store is being walked
  assign cmd_ready = (cst_ff == C_IDLE);
  assign take = cmd_valid && cmd_ready;
  assign boot_done = (cst_ff != C_BOOT);
  assign last_ack = nvm_ack && (nvm_row_ff == ROW_LAST);
  assign ri = cmd_row - ROW_ONE;

  // Field checks for writes and reads
  assign row_ok = (cmd_row != '0) && (cmd_row <= ROW_NUM);
  assign vpt_ok = (cmd_vpt >= 0 && cmd_vpt <= VPT_MAX) || cmd_vpt == VPT_SENT;
  assign val_ok = (cmd_mod >= MOD_MIN) && (cmd_mod <= MOD_MAX);
  assign loc_ok = (cmd_loc <= LOC_CACHE);
  assign wr_ok = row_ok && vpt_ok && val_ok && loc_ok;

  // Store port; the request holds until the store acknowledges
  assign nvm_req = (cst_ff != C_IDLE);
  assign nvm_we = (cst_ff == C_SAVE);
  assign nvm_addr = nvm_row_ff;
  assign nvm_wdata = {act_vpt_ff[nvm_row_ff], act_mod_ff[nvm_row_ff]};

  // Store walker: restore at power-on, dump on save
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      cst_ff <= C_BOOT;
      nvm_row_ff <= '0;
    end else begin
      case (cst_ff)
        C_BOOT, C_SAVE: begin
          if (last_ack) begin
            cst_ff <= C_IDLE;
            nvm_row_ff <= '0;
          end else if (nvm_ack) begin
            nvm_row_ff <= nvm_row_ff + ROW_ONE;
          end
        end
        C_IDLE: begin
          if (take && cmd_op == OP_SAVE) begin
            cst_ff <= C_SAVE;
            nvm_row_ff <= '0;
          end
        end
        default: cst_ff <= C_IDLE;
      endcase
    end
  end

  // Tables start empty so nothing modulates until restored
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      for (int i = 0; i < ROWS; i++) begin
        act_vpt_ff[i] <= VPT_SENT;
        act_mod_ff[i] <= '0;
        cch_vpt_ff[i] <= VPT_SENT;
        cch_mod_ff[i] <= '0;
      end
    end else if (cst_ff == C_BOOT && nvm_ack) begin
      act_vpt_ff[nvm_row_ff] <= nvm_rdata[63:32];
      act_mod_ff[nvm_row_ff] <= nvm_rdata[31:0];
      cch_vpt_ff[nvm_row_ff] <= nvm_rdata[63:32];
      cch_mod_ff[nvm_row_ff] <= nvm_rdata[31:0];
    end else if (take && cmd_op == OP_WRITE && wr_ok) begin
      if (cmd_loc == LOC_ACT) begin
        act_vpt_ff[ri] <= cmd_vpt;
        act_mod_ff[ri] <= cmd_mod;
      end else begin
        cch_vpt_ff[ri] <= cmd_vpt;
        cch_mod_ff[ri] <= cmd_mod;
      end
    end else if (take && cmd_op == OP_LOAD) begin
      act_vpt_ff <= cch_vpt_ff;
      act_mod_ff <= cch_mod_ff;
    end
  end

  // Set points switch together with the table on a load that carries them (cmd_has_sp)
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      vset_ff <= V_INIT;
      iset_ff <= I_INIT;
    end else if (take && cmd_op == OP_LOAD && cmd_has_sp) begin
      vset_ff <= cmd_vset;
      iset_ff <= cmd_iset;
    end
  end

  // One answer per command; save answers when its last row is acknowledged
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      rsp_valid <= 1'b0;
      rsp_err <= 1'b0;
      rsp_row <= '0;
      rsp_vpt <= '0;
      rsp_mod <= '0;
      rsp_loc <= '0;
    end else begin
      rsp_valid <= 1'b0;
      if (take && cmd_op != OP_SAVE) begin
        rsp_valid <= 1'b1;
        rsp_err <= 1'b0;
        rsp_row <= cmd_row;
        rsp_loc <= cmd_loc;
        rsp_vpt <= cmd_vpt;
        rsp_mod <= cmd_mod;
        case (cmd_op)
          OP_WRITE: rsp_err <= !wr_ok;
          OP_READ: begin
            if (row_ok && loc_ok) begin
              rsp_vpt <= (cmd_loc == LOC_ACT) ? act_vpt_ff[ri] : cch_vpt_ff[ri];
              rsp_mod <= (cmd_loc == LOC_ACT) ? act_mod_ff[ri] : cch_mod_ff[ri];
            end else begin
              rsp_err <= 1'b1;
            end
          end
          default: rsp_err <= 1'b0;
        endcase
      end else if (cst_ff == C_SAVE && last_ack) begin
        rsp_valid <= 1'b1;
        rsp_err <= 1'b0;
      end
    end
  end

  // Neighbouring points for the segment under the scan index
  assign ixp = (ix_ff == '0) ? '0 : ix_ff - ROW_ONE;
  assign vp = act_vpt_ff[ix_ff];
  assign mp = act_mod_ff[ix_ff];
  assign mp0 = act_mod_ff[ixp];
  assign dm = mp - mp0;
  assign dm_abs = (dm < 0) ? -dm : dm;
  assign dvin = vin_ff - act_vpt_ff[ixp];
  assign dden = vp - act_vpt_ff[ixp];

  assign dv.start = start_ff;
  assign dv.num = num_ff;
  assign dv.den = den_ff;

  // Linear scan finds the segment; slow but small, a sample takes under 110 cycles
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      ist_ff <= I_IDLE;
      ix_ff <= '0;
      vin_ff <= '0;
      m0_ff <= '0;
      neg_ff <= 1'b0;
      start_ff <= 1'b0;
      num_ff <= '0;
      den_ff <= '0;
      mod_val <= '0;
      mod_ok <= 1'b0;
    end else begin
      start_ff <= 1'b0;
      case (ist_ff)
        I_IDLE: begin
          if (analog_modulation_valid && boot_done) begin
            vin_ff <= {16'h0000, analog_modulation_input};
            ix_ff <= '0;
            ist_ff <= I_SCAN;
          end
        end
        I_SCAN: begin
          if (vp == VPT_SENT) begin
            mod_val <= mp0;
            mod_ok <= (ix_ff != '0);
            ist_ff <= I_IDLE;
          end else if (vin_ff <= vp || ix_ff == ROW_LAST) begin
            if (ix_ff == '0 || vin_ff > vp || dden == '0) begin
              mod_val <= mp;
              mod_ok <= 1'b1;
              ist_ff <= I_IDLE;
            end else begin
              m0_ff <= mp0;
              neg_ff <= (dm < 0);
              num_ff <= DIV_W'(dm_abs) * DIV_W'(dvin);
              den_ff <= DIV_W'(dden);
              start_ff <= 1'b1;
              ist_ff <= I_DIV;
            end
          end else begin
            ix_ff <= ix_ff + ROW_ONE;
          end
        end
        I_DIV: begin
          if (dv.done) begin
            mod_val <= neg_ff ? m0_ff - DW'(dv.quo) : m0_ff + DW'(dv.quo);
            mod_ok <= 1'b1;
            ist_ff <= I_IDLE;
          end
        end
        default: ist_ff <= I_IDLE;
      endcase
    end
  end

  mlt_div #(.W(DIV_W)) u_div (
    .core_clk(core_clk),
    .resetn(resetn),
    .dv(dv)
  );

  mlt_apply #(.V_MAX(V_MAX), .I_MAX(I_MAX)) u_apply (
    .core_clk(core_clk),
    .resetn(resetn),
    .ctl_sel(ctl_sel),
    .ctl_type(ctl_type),
    .vref(vset_ff),
    .iref(iset_ff),
    .mod_val(mod_val),
    .mod_ok(mod_ok),
    .vout(vout_sp),
    .iout(iout_sp)
  );

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!resetn);

  a_write_reject: assert property (take && cmd_op == OP_WRITE && !wr_ok
    |=> rsp_valid && rsp_err)
    else $error("bad write not refused");
  a_cache_write: assert property (take && cmd_op == OP_WRITE && wr_ok && cmd_loc == LOC_CACHE
    |=> cch_vpt_ff[rsp_row - ROW_ONE] == rsp_vpt && !rsp_err)
    else $error("cache row not written");
  a_active_write: assert property (take && cmd_op == OP_WRITE && wr_ok && cmd_loc == LOC_ACT
    |=> act_mod_ff[rsp_row - ROW_ONE] == rsp_mod)
    else $error("active row not written");
  a_read_answer: assert property (take && cmd_op == OP_READ && row_ok && loc_ok
    |=> rsp_valid && !rsp_err && rsp_row == $past(cmd_row) && rsp_loc == $past(cmd_loc))
    else $error("read answer wrong");
  a_boot_gate: assert property (cst_ff == C_BOOT |-> !cmd_ready && ist_ff == I_IDLE)
    else $error("table used before restore");
  a_load_copy: assert property (take && cmd_op == OP_LOAD
    |=> act_vpt_ff[0] == cch_vpt_ff[0] && act_mod_ff[ROWS-1] == cch_mod_ff[ROWS-1])
    else $error("cache not copied on load");
  a_load_setpt: assert property (take && cmd_op == OP_LOAD && cmd_has_sp
    |=> vset_ff == $past(cmd_vset) && iset_ff == $past(cmd_iset))
    else $error("load set points not applied");
  a_save_end: assert property (cst_ff == C_SAVE && last_ack |=> rsp_valid && cmd_ready)
    else $error("save did not finish after last row");
  a_sent_stop: assert property (ist_ff == I_SCAN && vp == VPT_SENT
    |=> ist_ff == I_IDLE && mod_ok == (ix_ff != '0))
    else $error("scan ran past end marker");
endmodule // mlt_core

// [src/mlt_div.sv]
// Unsigned restoring divider, one quotient bit per clock
`timescale 1ns/100ps
module mlt_div #(
  parameter int W = 48
) (
  input wire logic core_clk, // Clock
  input wire logic resetn, // Async reset, active low
  mlt_div_if.eng dv // Divide request and answer
);
  localparam int CW = $clog2(W + 1);
  localparam int LAT = W;
  logic [W-1:0] rem_ff;
  logic [W-1:0] quo_ff;
  logic [CW-1:0] cnt_ff;
  logic done_ff;
  logic [W:0] nxt_rem;
  logic [CW-1:0] age_ff;

  // Partial remainder with the next dividend bit shifted in
  assign nxt_rem = {rem_ff, quo_ff[W-1]};
  assign dv.quo = quo_ff;
  assign dv.done = done_ff;

  // Shift and subtract; a new start restarts the run
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      rem_ff <= '0;
      quo_ff <= '0;
      cnt_ff <= '0;
    end else if (dv.start) begin
      rem_ff <= '0;
      quo_ff <= dv.num;
      cnt_ff <= CW'(W);
    end else if (cnt_ff != '0) begin
      if (nxt_rem >= {1'b0, dv.den}) begin
        rem_ff <= W'(nxt_rem - {1'b0, dv.den});
        quo_ff <= {quo_ff[W-2:0], 1'b1};
      end else begin
        rem_ff <= nxt_rem[W-1:0];
        quo_ff <= {quo_ff[W-2:0], 1'b0};
      end
      cnt_ff <= cnt_ff - 1'b1;
    end
  end

  // Done pulses on the edge that settles the last bit
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      done_ff <= 1'b0;
    end else begin
      done_ff <= (cnt_ff == CW'(1)) && !dv.start;
    end
  end

  // Cycles since the last start; a counter keeps the latency check cheap for the tools
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      age_ff <= '0;
    end else if (dv.start) begin
      age_ff <= CW'(1);
    end else if (age_ff != '0 && age_ff != CW'(LAT + 1)) begin
      age_ff <= age_ff + 1'b1;
    end else begin
      age_ff <= '0;
    end
  end

  a_div_latency: assert property (@(posedge core_clk) disable iff (!resetn)
    dv.done == (age_ff == CW'(LAT + 1)))
    else $error("divider answer not on time");
endmodule // mlt_div

// [src/mlt_div_if.sv]
// Request and answer wires between the interpolator and its divider
`timescale 1ns/100ps
interface mlt_div_if #(parameter int W = 48);
  logic start;
  logic [W-1:0] num;
  logic [W-1:0] den;
  logic done;
  logic [W-1:0] quo;
  modport req (output start, num, den, input done, quo);
  modport eng (input start, num, den, output done, quo);
endinterface

// [src/mlt_pkg.sv]
// Shared constants and types for the modulation lookup-table engine
package mlt_pkg;
  localparam int ROWS = 50;
  localparam int ROW_W = 6;
  localparam int DW = 32;
  localparam int DIV_W = 48;
  localparam logic [ROW_W-1:0] ROW_LAST = 6'h31; // Index of the fiftieth row
  localparam logic [ROW_W-1:0] ROW_NUM = 6'h32; // Highest host row number
  localparam logic [ROW_W-1:0] ROW_ONE = 6'h01;
  localparam logic signed [DW-1:0] VPT_MAX = 32'h0000_2710; // 10.0 V in mV
  localparam logic signed [DW-1:0] VPT_SENT = 32'h0098_9298; // 9999 V end marker in mV
  localparam logic signed [DW-1:0] MOD_MAX = 32'h000F_4240; // +1000.0 in thousandths
  localparam logic signed [DW-1:0] MOD_MIN = 32'hFFF0_BDC0; // -1000.0 in thousandths
  localparam logic signed [63:0] MILLI = 64'h0000_0000_0000_03E8; // Unity gain
  localparam logic [1:0] LOC_ACT = 2'h0;
  localparam logic [1:0] LOC_CACHE = 2'h1;
  localparam logic [1:0] CTL_OFF = 2'h0;
  localparam logic [1:0] CTL_VOLT = 2'h1;
  localparam logic [1:0] CTL_CURR = 2'h2;
  localparam logic TYPE_MUL = 1'h0;
  localparam logic TYPE_ADD = 1'h1;
  typedef enum logic [1:0] {OP_WRITE, OP_READ, OP_SAVE, OP_LOAD} mlt_op_t;
endpackage

// [tb/mlt_core_tb.sv]
// Self-checking bench for the modulation lookup-table engine
`timescale 1ns/100ps
module mlt_core_tb;
  import mlt_pkg::*;
  logic core_clk = 1'b0;
  logic resetn = 1'b0;
  logic cmd_valid = 1'b0, cmd_has_sp = 1'b0, ctl_type = 1'b0, analog_modulation_valid = 1'b0;
  logic cmd_ready, rsp_valid, rsp_err, nvm_req, nvm_we, nvm_ack, boot_done, mod_ok;
  mlt_op_t cmd_op = OP_READ;
  logic [5:0] cmd_row = 6'h01, rsp_row, nvm_addr;
  logic [1:0] cmd_loc = 2'h0, rsp_loc, ctl_sel = 2'h0;
  logic signed [31:0] cmd_vpt = 32'h0, cmd_mod = 32'h0, cmd_vset = 32'h0, cmd_iset = 32'h0;
  logic signed [31:0] rsp_vpt, rsp_mod, mod_val, vout_sp, iout_sp;
  logic [15:0] analog_modulation_input = 16'h0;
  logic [63:0] nvm_wdata, nvm_rdata;
  logic [3:0] lat = 4'h0;
  int miscompares = 0, cmp_count = 0, cycles = 0;

  // Voltage ceiling lowered so the clamp is reachable
  mlt_core #(.V_MAX(32'h0000_1770)) dut (.core_clk, .resetn, .cmd_valid, .cmd_ready, .cmd_op,
    .cmd_row, .cmd_vpt, .cmd_mod, .cmd_loc, .cmd_has_sp, .cmd_vset, .cmd_iset, .rsp_valid,
    .rsp_err, .rsp_row, .rsp_vpt, .rsp_mod, .rsp_loc, .analog_modulation_valid,
    .analog_modulation_input, .ctl_sel, .ctl_type, .nvm_req, .nvm_we, .nvm_addr, .nvm_wdata,
    .nvm_rdata, .nvm_ack, .boot_done, .mod_val, .mod_ok, .vout_sp, .iout_sp);
  mlt_nvm_model nvm (.core_clk, .nvm_req, .nvm_we, .nvm_addr, .nvm_wdata, .nvm_rdata,
    .nvm_ack, .lat);

  // 25 MHz clock
  always #20 core_clk = ~core_clk;

  // Cut a hang short
  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (cycles == 6000) begin
      miscompares++;
      complete_run();
    end
  end

  task automatic complete_run();
    $display("comparisons %0d miscompares %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Hold the command until taken, then wait for its answer
  task automatic cmd(input mlt_op_t op, input logic [5:0] r, input logic [31:0] vp, md,
      input logic [1:0] l);
    int n;
    @(negedge core_clk);
    cmd_valid = 1'b1;
    cmd_op = op;
    cmd_row = r;
    cmd_vpt = vp;
    cmd_mod = md;
    cmd_loc = l;
    for (n = 0; n < 2000 && cmd_ready !== 1'b1; n++) @(negedge core_clk);
    @(negedge core_clk);
    cmd_valid = 1'b0;
    for (n = 0; n < 2000 && rsp_valid !== 1'b1; n++) @(negedge core_clk);
    chk("rsp_valid", 32'h1, {31'h0, rsp_valid});
  endtask

  task automatic wr(input logic [5:0] r, input logic [31:0] vp, md, input logic [1:0] l,
      input logic e);
    cmd(OP_WRITE, r, vp, md, l);
    chk("rsp_err", {31'h0, e}, {31'h0, rsp_err});
  endtask

  task automatic rd(input logic [5:0] r, input logic [1:0] l, input logic [31:0] ev, em);
    cmd(OP_READ, r, 32'h0, 32'h0, l);
    chk("rsp_err", 32'h0, {31'h0, rsp_err});
    chk("rsp_row", {26'h0, r}, {26'h0, rsp_row});
    chk("rsp_vpt", ev, rsp_vpt);
    chk("rsp_mod", em, rsp_mod);
    chk("rsp_loc", {30'h0, l}, {30'h0, rsp_loc});
  endtask

  // One input sample; the scan plus divide is bounded at about a hundred cycles
  task automatic samp(input logic [15:0] v, input logic [31:0] em, ev, ei);
    @(negedge core_clk);
    analog_modulation_input = v;
    analog_modulation_valid = 1'b1;
    @(negedge core_clk);
    analog_modulation_valid = 1'b0;
    repeat (120) @(negedge core_clk);
    chk("mod_ok", 32'h1, {31'h0, mod_ok});
    chk("mod_val", em, mod_val);
    chk("vout_sp", ev, vout_sp);
    chk("iout_sp", ei, iout_sp);
  endtask

  task automatic t_boot();
    int n;
    resetn = 1'b0;
    repeat (5) @(negedge core_clk);
    resetn = 1'b1;
    for (n = 0; n < 500 && boot_done !== 1'b1; n++) @(negedge core_clk);
    chk("boot_done", 32'h1, {31'h0, boot_done});
    rd(6'h02, 2'h0, 32'h0000_03E8, 32'h0000_07D0);
    rd(6'h02, 2'h1, 32'h0000_03E8, 32'h0000_07D0);
  endtask

  task automatic t_write();
    wr(6'h03, 32'h0000_07D0, MOD_MIN, 2'h1, 1'b0);
    rd(6'h03, 2'h0, VPT_SENT, 32'h0);
    rd(6'h03, 2'h1, 32'h0000_07D0, MOD_MIN);
    wr(6'h32, VPT_MAX, MOD_MAX, 2'h0, 1'b0);
    rd(6'h32, 2'h0, VPT_MAX, MOD_MAX);
  endtask

  task automatic t_refuse();
    wr(6'h00, 32'h0, 32'h0000_0001, 2'h0, 1'b1);
    wr(6'h33, 32'h0, 32'h0000_0001, 2'h0, 1'b1);
    wr(6'h01, 32'h0000_2711, 32'h0000_0001, 2'h0, 1'b1);
    wr(6'h01, 32'h0, 32'h000F_4241, 2'h0, 1'b1);
    wr(6'h01, 32'h0, 32'h0000_0001, 2'h2, 1'b1);
    rd(6'h01, 2'h0, 32'h0, 32'h0);
  endtask

  task automatic t_mod();
    cmd_has_sp = 1'b1;
    cmd_vset = 32'h0000_0FA0;
    cmd_iset = 32'h0000_0BB8;
    cmd(OP_LOAD, 6'h01, 32'h0, 32'h0, 2'h0);
    chk("rsp_err", 32'h0, {31'h0, rsp_err});
    rd(6'h03, 2'h0, 32'h0000_07D0, MOD_MIN);
    rd(6'h32, 2'h0, VPT_SENT, 32'h0);
    samp(16'h01F4, 32'h0000_03E8, 32'h0000_0FA0, 32'h0000_0BB8);
    ctl_sel = CTL_VOLT;
    samp(16'h01F4, 32'h0000_03E8, 32'h0000_0FA0, 32'h0000_0BB8);
    samp(16'h03E8, 32'h0000_07D0, 32'h0000_1770, 32'h0000_0BB8);
    ctl_type = TYPE_ADD;
    samp(16'h01F4, 32'h0000_03E8, 32'h0000_1388, 32'h0000_0BB8);
    samp(16'h05DC, 32'hFFF8_62C8, 32'h0, 32'h0000_0BB8);
    samp(16'h1388, MOD_MIN, 32'h0, 32'h0000_0BB8);
    ctl_sel = CTL_CURR;
    ctl_type = TYPE_MUL;
    samp(16'h03E8, 32'h0000_07D0, 32'h0000_0FA0, 32'h0000_1770);
  endtask

  task automatic t_load();
    wr(6'h01, 32'h0, 32'h0000_0BB8, 2'h1, 1'b0);
    cmd_has_sp = 1'b0;
    cmd(OP_LOAD, 6'h01, 32'h0, 32'h0, 2'h0);
    rd(6'h01, 2'h0, 32'h0, 32'h0000_0BB8);
    samp(16'h0000, 32'h0000_0BB8, 32'h0000_0FA0, 32'h0000_2328);
  endtask

  // Save with a slow store, then power up again from what was kept
  task automatic t_save();
    lat = 4'h3;
    cmd(OP_SAVE, 6'h01, 32'h0, 32'h0, 2'h0);
    chk("rsp_err", 32'h0, {31'h0, rsp_err});
    chk("cmd_ready", 32'h1, {31'h0, cmd_ready});
    chk("nvm_req", 32'h0, {31'h0, nvm_req});
    chk("stored point", 32'h0000_07D0, nvm.mem[2][63:32]);
    chk("stored value", MOD_MIN, nvm.mem[2][31:0]);
    chk("stored marker", VPT_SENT, nvm.mem[49][63:32]);
    lat = 4'h0;
    t_boot();
    rd(6'h01, 2'h0, 32'h0, 32'h0000_0BB8);
  endtask

  // Main sequence
  initial begin
    t_boot();
    t_write();
    t_refuse();
    t_mod();
    t_load();
    t_save();
    complete_run();
  end
endmodule // mlt_core_tb

// [tb/mlt_nvm_model.sv]
// Behavioural non-volatile row store that answers the engine's store bus
`timescale 1ns/100ps
module mlt_nvm_model import mlt_pkg::*; (
  input wire logic core_clk, // Clock
  input wire logic nvm_req, // Access request
  input wire logic nvm_we, // Access is a write
  input wire logic [5:0] nvm_addr, // Row 0..49
  input wire logic [63:0] nvm_wdata, // Row to keep
  output logic [63:0] nvm_rdata, // Row read back
  output logic nvm_ack, // Access finished
  input wire logic [3:0] lat // Extra wait cycles per row
);
  logic [63:0] mem [0:49];
  logic [3:0] wait_ff;
  // Stored image: two points, then end markers
  initial begin
    for (int i = 0; i < 50; i++) mem[i] = {VPT_SENT, 32'h0000_0000};
    mem[0] = 64'h0;
    mem[1] = {32'h0000_03E8, 32'h0000_07D0};
    nvm_ack = 1'b0;
    nvm_rdata = 64'h0;
    wait_ff = 4'h0;
  end
  // One row per ack; data toggles when idle so stale data is never mistaken for a row
  always @(negedge core_clk) begin
    if (nvm_ack || !nvm_req) begin
      nvm_ack <= 1'b0;
      nvm_rdata <= ~nvm_rdata;
      wait_ff <= 4'h0;
    end else if (wait_ff < lat) begin
      wait_ff <= wait_ff + 4'h1;
      nvm_rdata <= ~nvm_rdata;
    end else begin
      nvm_ack <= 1'b1;
      if (nvm_we) mem[nvm_addr] <= nvm_wdata;
      else nvm_rdata <= mem[nvm_addr];
    end
  end
endmodule // mlt_nvm_model
